// ===== ast_pkg.sv
// Constants, field positions and state types of the async serial port.
// Assumes a 200 MHz pclk and 32-bit APB with word-aligned registers.
package ast_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int INSTR_CYCLE_PS = 20000;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] HALF_BIT_TICK = 4'h7;
  localparam logic [3:0] LAST_BIT_TICK = 4'hF;
  localparam logic [1:0] LOW_SPEED_LAST = 2'h3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_IRQ_FLAGS_ONE = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLES_ONE = 8'h08;
  localparam logic [7:0] OFS_IRQ_PRIORITY_ONE = 8'h0C;
  localparam logic [7:0] OFS_RECEIVE_STATUS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_TRANSMIT_BUFFER = 8'h14;
  localparam logic [7:0] OFS_TRANSMIT_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h1C;
  localparam logic [7:0] OFS_RECEIVE_BUFFER = 8'h20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_RX = 5;
  localparam int BIT_TX = 4;
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_RX_NINE = 6;
  localparam int BIT_CONT_RECEIVE = 4;
  localparam int BIT_ADDRESS_DETECT = 3;
  localparam int BIT_FRAMING_ERROR = 2;
  localparam int BIT_OVERRUN_ERROR = 1;
  localparam int BIT_RX_NINTH = 0;
  localparam int BIT_TX_NINE = 6;
  localparam int BIT_TRANSMITTER_ENABLE = 5;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_HIGH_SPEED_BAUD = 2;
  localparam int BIT_TX_SHIFTER_EMPTY = 1;
  localparam int BIT_TX_NINTH = 0;
  localparam logic [7:0] RST_IRQ_PRIORITY_ONE = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic {TX_IDLE, TX_SHIFT} ast_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HALT} ast_rx_state_type;

endpackage : ast_pkg

// ===== ast_serial.sv
// Async serial transmitter and receiver with APB register file.
// Assumes rx_pin is already synchronous to pclk; sleep_mode comes from the core.
`timescale 1ns/1ps
module ast_serial
  import ast_pkg::*;
#(
  parameter int DIV_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  output logic tx_pin,
  output logic tx_irq,
  output logic rx_irq,
  output logic rx_irq_high
);

  if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_bad_width
    $error("DIV_WIDTH must lie in 1..8");
  end

  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] pie;
    logic [7:0] ipr;
    logic serial_port_enable;
    logic rx9;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error;
    logic overrun_error;
    logic rx_ninth_bit;
    logic tx9;
    logic transmitter_enable;
    logic sync;
    logic high_speed_baud_select;
    logic tx_ninth_bit;
    logic [DIV_WIDTH-1:0] divisor;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic tx_buffer_empty_flag;
    logic [3:0] tx_buffer_empty_flag_wait;
    logic [7:0] rcbuf;
    logic rx_complete_flag;
    logic [DIV_WIDTH-1:0] brg_cnt;
    logic [1:0] pre_cnt;
    ast_tx_state_type tx_st;
    logic [3:0] tx_tick;
    logic [3:0] tx_bits;
    logic [10:0] tx_sh;
    logic tx_pin;
    ast_rx_state_type rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic [31:0] prdata;
  } ast_state_type;

  ast_state_type r;
  ast_state_type next_r;

  // ****************************************
  // Bus decode
  // ****************************************
  logic hit;
  logic wr;
  logic rd;
  logic [7:0] rdval;
  logic sample_tick;
  logic [7:0] rx_word;
  logic rx_ninth;
  logic buf_read;

  always_comb begin
    // Upper address bits must be zero; only aligned words are mapped
    hit = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= OFS_RECEIVE_BUFFER);
    rdval = RST_BYTE;
    unique case (paddr[7:0])
      OFS_INTERRUPT_CONTROL: rdval = r.interrupt_control;
      OFS_IRQ_FLAGS_ONE: begin
        rdval[BIT_RX] = r.rx_complete_flag;
        rdval[BIT_TX] = r.tx_buffer_empty_flag;
      end
      OFS_IRQ_ENABLES_ONE: rdval = r.pie;
      OFS_IRQ_PRIORITY_ONE: rdval = r.ipr;
      OFS_RECEIVE_STATUS_CONTROL: begin
        rdval[BIT_SERIAL_PORT_ENABLE] = r.serial_port_enable;
        rdval[BIT_RX_NINE] = r.rx9;
        rdval[BIT_CONT_RECEIVE] = r.continuous_receive_enable;
        rdval[BIT_ADDRESS_DETECT] = r.address_detect_enable;
        rdval[BIT_FRAMING_ERROR] = r.framing_error;
        rdval[BIT_OVERRUN_ERROR] = r.overrun_error;
        rdval[BIT_RX_NINTH] = r.rx_ninth_bit;
      end
      OFS_TRANSMIT_BUFFER: rdval = r.txbuf;
      OFS_TRANSMIT_STATUS_CONTROL: begin
        rdval[BIT_TX_NINE] = r.tx9;
        rdval[BIT_TRANSMITTER_ENABLE] = r.transmitter_enable;
        rdval[BIT_SYNC_MODE] = r.sync;
        rdval[BIT_HIGH_SPEED_BAUD] = r.high_speed_baud_select;
        rdval[BIT_TX_SHIFTER_EMPTY] = (r.tx_st == TX_IDLE);
        rdval[BIT_TX_NINTH] = r.tx_ninth_bit;
      end
      OFS_BAUD_DIVISOR: rdval = 8'(r.divisor);
      OFS_RECEIVE_BUFFER: rdval = r.rcbuf;
      default: rdval = RST_BYTE;
    endcase
  end

  assign wr = psel && penable && pwrite && hit;
  assign rd = psel && penable && !pwrite && hit;
  // Zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = r.prdata;
  assign tx_pin = r.tx_pin;
  assign tx_irq = r.tx_buffer_empty_flag && r.pie[BIT_TX];
  assign rx_irq = r.rx_complete_flag && r.pie[BIT_RX] && r.interrupt_control[BIT_GLOBAL_IRQ_ENABLE];
  assign rx_irq_high = r.ipr[BIT_RX];

  // Received bits land at the top; an 8-bit frame leaves them one place high
  assign rx_word = r.rx9 ? r.rx_sh[7:0] : r.rx_sh[8:1];
  assign rx_ninth = r.rx_sh[8];
  // Only a read of the buffer itself frees room for a completing word
  assign buf_read = rd && (paddr[7:0] == OFS_RECEIVE_BUFFER);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    sample_tick = 1'b0;
    if (psel && !penable) begin
      // Refused addresses read as zero
      next_r.prdata = hit ? {24'h000000, rdval} : 32'h00000000;
    end

    // Baud generator; sleep freezes bit timing on both paths, but a full buffer still loads
    if (r.serial_port_enable && !r.sync && !sleep_mode) begin
      if (r.brg_cnt == '0) begin
        next_r.brg_cnt = r.divisor;
        next_r.pre_cnt = r.pre_cnt + 2'h1;
        sample_tick = r.high_speed_baud_select || (r.pre_cnt == LOW_SPEED_LAST);
      end else begin
        next_r.brg_cnt = r.brg_cnt - 1'b1;
      end
    end

    // Delayed clear of the buffer-empty flag
    if (r.tx_buffer_empty_flag_wait != 4'h0) begin
      next_r.tx_buffer_empty_flag_wait = r.tx_buffer_empty_flag_wait - 4'h1;
      if (r.tx_buffer_empty_flag_wait == 4'h1) begin
        next_r.tx_buffer_empty_flag = 1'b0;
      end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    // Dropping either enable aborts a frame in flight; pin returns to mark
    if (!(r.serial_port_enable && r.transmitter_enable && !r.sync)) begin
      next_r.tx_st = TX_IDLE;
    end else if (r.tx_st == TX_IDLE) begin
      // Loading empties the buffer, so the flag sets and a pending clear is dropped
      if (r.txbuf_full) begin
        next_r.tx_sh = {1'b1, r.tx9 ? r.tx_ninth_bit : 1'b1, r.txbuf, 1'b0};
        next_r.tx_bits = r.tx9 ? 4'hB : 4'hA;
        next_r.tx_tick = 4'h0;
        next_r.tx_st = TX_SHIFT;
        next_r.txbuf_full = 1'b0;
        next_r.tx_buffer_empty_flag = 1'b1;
        next_r.tx_buffer_empty_flag_wait = 4'h0;
      end
    end else if (sample_tick) begin
      next_r.tx_tick = r.tx_tick + 4'h1;
      if (r.tx_tick == LAST_BIT_TICK) begin
        next_r.tx_sh = {1'b1, r.tx_sh[10:1]};
        next_r.tx_bits = r.tx_bits - 4'h1;
        if (r.tx_bits == 4'h1) begin
          next_r.tx_st = TX_IDLE;
        end
      end
    end

    // ****************************************
    // Receiver
    // ****************************************
    if (sample_tick && r.continuous_receive_enable) begin
      next_r.rx_tick = r.rx_tick + 4'h1;
      unique case (r.rx_st)
        RX_IDLE: begin
          next_r.rx_tick = 4'h0;
          if (!rx_pin) begin
            next_r.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (r.rx_tick == HALF_BIT_TICK) begin
            next_r.rx_tick = 4'h0;
            next_r.rx_bits = 4'h0;
            // A start bit gone high by mid-bit is noise
            next_r.rx_st = rx_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (r.rx_tick == LAST_BIT_TICK) begin
            next_r.rx_sh = {rx_pin, r.rx_sh[8:1]};
            next_r.rx_bits = r.rx_bits + 4'h1;
            if (r.rx_bits == (r.rx9 ? 4'h8 : 4'h7)) begin
              next_r.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (r.rx_tick == LAST_BIT_TICK) begin
            next_r.rx_st = RX_IDLE;
            if (r.address_detect_enable && r.rx9 && !rx_ninth) begin
              next_r.rx_st = RX_IDLE;
            end else if (r.rx_complete_flag && !buf_read) begin
              // Unread word is kept; receiver waits for continuous receive to drop
              next_r.overrun_error = 1'b1;
              next_r.rx_st = RX_HALT;
            end else begin
              next_r.rcbuf = rx_word;
              next_r.rx_ninth_bit = r.rx9 ? rx_ninth : 1'b0;
              next_r.framing_error = !rx_pin;
            end
          end
        end
        RX_HALT: next_r.rx_st = RX_HALT;
      endcase
    end

    // ****************************************
    // Register writes and read effects
    // ****************************************
    if (wr) begin
      unique case (paddr[7:0])
        OFS_INTERRUPT_CONTROL: next_r.interrupt_control = pwdata[7:0];
        OFS_IRQ_ENABLES_ONE: next_r.pie = pwdata[7:0];
        OFS_IRQ_PRIORITY_ONE: next_r.ipr = pwdata[7:0];
        OFS_RECEIVE_STATUS_CONTROL: begin
          next_r.serial_port_enable = pwdata[BIT_SERIAL_PORT_ENABLE];
          next_r.rx9 = pwdata[BIT_RX_NINE];
          next_r.continuous_receive_enable = pwdata[BIT_CONT_RECEIVE];
          next_r.address_detect_enable = pwdata[BIT_ADDRESS_DETECT];
        end
        OFS_TRANSMIT_BUFFER: begin
          next_r.txbuf = pwdata[7:0];
          next_r.txbuf_full = 1'b1;
          next_r.tx_buffer_empty_flag_wait = 4'(INSTR_CYCLE_CLKS);
        end
        OFS_TRANSMIT_STATUS_CONTROL: begin
          next_r.tx9 = pwdata[BIT_TX_NINE];
          next_r.transmitter_enable = pwdata[BIT_TRANSMITTER_ENABLE];
          next_r.sync = pwdata[BIT_SYNC_MODE];
          next_r.high_speed_baud_select = pwdata[BIT_HIGH_SPEED_BAUD];
          next_r.tx_ninth_bit = pwdata[BIT_TX_NINTH];
          if (pwdata[BIT_TRANSMITTER_ENABLE] && !r.transmitter_enable) begin
            next_r.tx_buffer_empty_flag = 1'b1;
            next_r.tx_buffer_empty_flag_wait = 4'h0;
          end
        end
        OFS_BAUD_DIVISOR: next_r.divisor = pwdata[DIV_WIDTH-1:0];
        // Flags and receive buffer ignore writes
        default: next_r.interrupt_control = next_r.interrupt_control;
      endcase
    end
    if (!next_r.continuous_receive_enable) begin
      next_r.framing_error = 1'b0;
      next_r.overrun_error = 1'b0;
      next_r.rx_st = RX_IDLE;
    end

    // Reading the buffer clears the flag; a word landing now still sets it
    if (buf_read) begin
      next_r.rx_complete_flag = 1'b0;
    end
    if (sample_tick && r.continuous_receive_enable && r.rx_st == RX_STOP && r.rx_tick == LAST_BIT_TICK
        && !(r.address_detect_enable && r.rx9 && !rx_ninth) && !(r.rx_complete_flag && !buf_read)) begin
      next_r.rx_complete_flag = 1'b1;
    end

    next_r.tx_pin = (next_r.tx_st == TX_SHIFT) ? next_r.tx_sh[0] : 1'b1;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Line at mark and shifter empty out of reset
      r <= '0;
      r.ipr <= RST_IRQ_PRIORITY_ONE;
      r.tx_st <= TX_IDLE;
      r.rx_st <= RX_IDLE;
      r.tx_sh <= 11'h7FF;
      r.tx_pin <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

endmodule : ast_serial

// ===== ast_serial_asserts.sv
// Concurrent checks on the serial port pins and its APB slave answers.
// Assumes it is bound into ast_serial and sees only that module's ports.
`timescale 1ns/1ps
module ast_chk
  import ast_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  input wire logic tx_pin,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic rx_irq_high
);
  // Bus idle count: a buffer write may still drop the pin a few clocks later
  logic [2:0] quiet;
  logic [2:0] next_quiet;
  wire acc = psel && penable;
  wire bad = paddr > 32'h20 || paddr[1:0] != 2'h0;
  wire txw = acc && pwrite && !bad && paddr[7:0] == OFS_TRANSMIT_BUFFER;
  always_comb next_quiet = psel ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) quiet <= 3'h0;
    else quiet <= next_quiet;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_err_decode: assert property (pslverr == (acc && bad))
    else $error("pslverr does not match address decode");
  a_err_nodata: assert property (acc && bad |-> prdata == 32'h0)
    else $error("read data not zero on refused access");
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase not answered at once");
  a_prio_follow: assert property (acc && pwrite && paddr == 32'h0C |=> rx_irq_high == $past(pwdata[5]))
    else $error("priority output does not follow its bit");
  a_flag_holds: assert property (txw && tx_irq |=> tx_irq [*3])
    else $error("buffer empty flag cleared too early");
  a_sleep_freeze: assert property (sleep_mode [*2] ##0 quiet > 3'h3 |=> $stable(tx_pin))
    else $error("transmit pin moved during sleep");
  a_reset_idle: assert property ($past(!presetn) |-> tx_pin && !tx_irq && !rx_irq && rx_irq_high)
    else $error("outputs not idle after reset");
  a_start_len: assert property ($fell(tx_pin) |=> !tx_pin [*8])
    else $error("start bit too short");
  c_tx_frame: cover property ($fell(tx_pin));
  c_rx_word: cover property ($rose(rx_irq));
  c_refused: cover property (acc && bad);
endmodule : ast_chk

// ===== ast_peer.sv
// Line-side partner: drives frames onto rx_pin and decodes tx_pin frames.
// Assumes the bench sets bitlen (pclk cycles per bit) and nine beforehand.
`timescale 1ns/1ps
module ast_peer (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_pin
);
  int bitlen = 16;
  bit nine = 1'b0;
  int frames = 0;
  logic [9:0] got;
  logic [10:0] f;
  event fdone;
  initial rx_pin = 1'b1;
  // Start low, data LSB first, stop, then idle at mark: one bit after a 9-bit frame, two after an 8-bit one
  task automatic send(logic [8:0] d, logic stp);
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_pin <= f[i];
      repeat (bitlen) @(posedge clk);
    end
    rx_pin <= 1'b1;
    repeat (bitlen) @(posedge clk);
  endtask : send
  // Mid-bit sampling timed from the falling start edge
  always begin
    @(negedge tx_pin);
    repeat (bitlen / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (bitlen) @(posedge clk);
      got[i] = tx_pin;
    end
    if (!nine) got = {got[8], 1'b0, got[7:0]};
    frames++;
    -> fdone;
  end
endmodule : ast_peer

// ===== test_async_serial_txrx.sv
// Self-checking bench for the async serial port with a line partner.
// Assumes ast_pkg, ast_serial, ast_peer and ast_chk are compiled first.
`timescale 1ns/1ps
module test_async_serial_txrx import ast_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, rx_pin, tx_pin, tx_irq, rx_irq, rx_irq_high;
  logic [32:0] exq[$];
  logic [9:0] fq[$];
  logic [7:0] b;
  int fails = 0;
  int compares = 0;
  int seed = 32'hB68D698E;
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  ast_serial uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_pin, .sleep_mode, .tx_pin, .tx_irq, .rx_irq, .rx_irq_high);
  ast_peer peer (.clk(pclk), .tx_pin, .rx_pin);
  always #2.5 pclk = ~pclk;
  task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(logic [7:0] a, logic w, logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(logic [7:0] a, logic [32:0] e);
    exq.push_back(e);
    apb(a, 1'b0, 8'h00);
  endtask : rd
  task automatic rx_word(logic [8:0] d, logic stp, logic [7:0] st);
    peer.send(d, stp);
    chk("rx_irq", 33'h1, 33'(rx_irq));
    rd(OFS_RECEIVE_STATUS_CONTROL, {25'h0, st});
    rd(OFS_RECEIVE_BUFFER, {25'h0, d[7:0]});
  endtask : rx_word
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk("read", exq.size() > 0 ? exq.pop_front() : 33'h0, {pslverr, prdata});
    end
  end
  always @(peer.fdone) chk("frame", 33'(fq.pop_front()), 33'(peer.got));
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    results();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {pclk, psel, penable, pwrite, sleep_mode, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rv[i]) rd(8'(4 * i), {25'h0, rv[i]});
    rd(8'h24, 33'h100000000);
    rd(8'h02, 33'h100000000);
    $display("test reset done");
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'h80);
    apb(OFS_TRANSMIT_STATUS_CONTROL, 1'b1, 8'h24);
    rd(OFS_IRQ_FLAGS_ONE, 33'h10);
    chk("tx_irq", 33'h0, 33'(tx_irq));
    apb(OFS_IRQ_ENABLES_ONE, 1'b1, 8'h10);
    chk("tx_irq", 33'h1, 33'(tx_irq));
    for (int i = 0; i < 4; i++) begin
      peer.nine = i == 2;
      peer.bitlen = i == 3 ? 64 : 16;
      apb(OFS_TRANSMIT_STATUS_CONTROL, 1'b1, i == 2 ? 8'h65 : i == 3 ? 8'h20 : 8'h24);
      b = 8'($random(seed));
      fq.push_back({1'b1, i == 2, b});
      apb(OFS_TRANSMIT_BUFFER, 1'b1, b);
      if (i == 1) begin
        repeat (3) @(posedge pclk);
        rd(OFS_IRQ_FLAGS_ONE, 33'h0);
      end
      while (i > 0 && peer.frames < i + 1) @(posedge pclk);
    end
    rd(OFS_IRQ_FLAGS_ONE, 33'h10);
    rd(OFS_TRANSMIT_STATUS_CONTROL, 33'h20);
    repeat (64) @(posedge pclk);
    rd(OFS_TRANSMIT_STATUS_CONTROL, 33'h22);
    $display("test transmit done");
    peer.bitlen = 16;
    apb(OFS_TRANSMIT_STATUS_CONTROL, 1'b1, 8'h24);
    apb(OFS_IRQ_ENABLES_ONE, 1'b1, 8'h20);
    apb(OFS_INTERRUPT_CONTROL, 1'b1, 8'h80);
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'h90);
    rx_word({1'b0, 8'($random(seed))}, 1'b1, 8'h90);
    chk("rx_irq_high", 33'h1, 33'(rx_irq_high));
    apb(OFS_IRQ_PRIORITY_ONE, 1'b1, 8'h00);
    chk("rx_irq_high", 33'h0, 33'(rx_irq_high));
    rd(OFS_IRQ_FLAGS_ONE, 33'h10);
    rx_word({1'b0, 8'($random(seed))}, 1'b0, 8'h94);
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'h80);
    rd(OFS_RECEIVE_STATUS_CONTROL, 33'h80);
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'h90);
    b = 8'($random(seed));
    peer.send({1'b0, b}, 1'b1);
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    rd(OFS_RECEIVE_STATUS_CONTROL, 33'h92);
    rd(OFS_RECEIVE_BUFFER, {25'h0, b});
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'h80);
    rd(OFS_RECEIVE_STATUS_CONTROL, 33'h80);
    $display("test receive done");
    peer.nine = 1'b1;
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'hD8);
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    chk("rx_irq", 33'h0, 33'(rx_irq));
    rx_word({1'b1, 8'($random(seed))}, 1'b1, 8'hD9);
    apb(OFS_RECEIVE_STATUS_CONTROL, 1'b1, 8'hD0);
    rx_word({1'b0, 8'($random(seed))}, 1'b1, 8'hD0);
    $display("test address detect done");
    peer.nine = 1'b0;
    sleep_mode <= 1'b1;
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    chk("rx_irq", 33'h0, 33'(rx_irq));
    sleep_mode <= 1'b0;
    $display("test sleep done");
    apb(OFS_TRANSMIT_STATUS_CONTROL, 1'b1, 8'h34);
    apb(OFS_TRANSMIT_BUFFER, 1'b1, 8'h5A);
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    chk("rx_irq", 33'h0, 33'(rx_irq));
    rd(OFS_TRANSMIT_STATUS_CONTROL, 33'h36);
    $display("test sync select done");
    results();
  end
endmodule : test_async_serial_txrx
bind ast_serial ast_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rx_pin, .sleep_mode, .tx_pin, .tx_irq, .rx_irq, .rx_irq_high);
